// >>> sar_defs.vh
// sar_defs.vh: register offsets, field positions and timing counts
// assumes word-aligned AHB-Lite access and a 100 ns hclk
`ifndef SAR_DEFS_VH
`define SAR_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_SC1 8'h00
`define OFS_SC2 8'h04
`define OFS_SC3 8'h08
`define OFS_SC4 8'h0C
`define OFS_RH 8'h10
`define OFS_RL 8'h14
`define OFS_CVH 8'h18
`define OFS_CVL 8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define SC1_FLAG 7
`define SC1_IRQEN 6
`define SC1_CONT 5
`define SC1_CHAN 4:0
`define SC2_BUSY 7
`define SC2_HWTRIG 6
`define SC2_CMPEN 5
`define SC2_CMPGT 4
`define SC3_LOWPWR 7
`define SC3_DIV 6:5
`define SC3_LONG 4
`define SC3_MODE 3:2
`define SC3_CLK 1:0
`define SC4_CMPALL 5
`define SC4_DEPTH 2:0
`define HI_NIBBLE 3:0

// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define CHAN_OFF 5'h1F
`define MODE_8 2'h0
`define MODE_12 2'h1
`define MODE_10 2'h2
`define CLK_BUS 2'h0
`define CLK_BUS_HALF 2'h1
`define CLK_ALT 2'h2
`define CLK_ASYNC 2'h3
`define SC1_RESET 8'h1F

// ----------------------------------------
// timing
// ----------------------------------------
`define HCLK_PERIOD_NS 100
`define ASYNC_STARTUP_NS 5000
// 5000 ns over a 100 ns hclk, kept a plain number so it can be sized
`define ASYNC_STARTUP_CYCLES 50
`define START_BUS_CYCLES 5
`define SAMPLE_SHORT_TICKS 4
`define SAMPLE_LONG_TICKS 24
`define FIRST_EXTRA_TICKS 3
`define APPROX_8_TICKS 13
`define APPROX_HI_TICKS 16

`endif

// >>> converter_clock_divider.v
// converter_clock_divider: one-cycle converter clock ticks from hclk
// assumes alt and async ticks are single-cycle pulses synchronous to hclk
`timescale 1ns/1ps
`include "sar_defs.vh"
module converter_clock_divider (
  input wire hclk,
  input wire hresetn,
  input wire run,
  input wire [1:0] input_clock_select,
  input wire [1:0] clock_divide,
  input wire alt_clock_tick,
  input wire async_clock_tick,
  output reg tick
);
  reg half;
  reg [2:0] div_cnt;
  reg src;
  reg [2:0] div_top;

  // ----------------------------------------
  // source select and divide ratio
  // ----------------------------------------
  always @* begin
    case (input_clock_select)
      `CLK_BUS: src = 1'b1;
      `CLK_BUS_HALF: src = half;
      `CLK_ALT: src = alt_clock_tick;
      default: src = async_clock_tick;
    endcase
    case (clock_divide)
      2'h0: div_top = 3'h0;
      2'h1: div_top = 3'h1;
      2'h2: div_top = 3'h3;
      default: div_top = 3'h7;
    endcase
  end

  // stopped while idle, so each conversion started from idle begins from a clean phase; continuous repeats keep the running phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half <= 1'b0;
      div_cnt <= 3'h0;
      tick <= 1'b0;
    end else if (!run) begin
      half <= 1'b0;
      div_cnt <= 3'h0;
      tick <= 1'b0;
    end else begin
      half <= ~half;
      tick <= 1'b0;
      if (src) begin
        if (div_cnt == div_top) begin
          div_cnt <= 3'h0;
          tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 3'h1;
        end
      end
    end
  end
endmodule

// >>> result_compare.v
// result_compare: resolution fit and limit compare of a raw result
// assumes the core delivers a right-justified result
`timescale 1ns/1ps
`include "sar_defs.vh"
module result_compare (
  input wire [11:0] raw,
  input wire [1:0] res_mode,
  input wire [11:0] compare_value,
  input wire compare_greater_select,
  output reg [11:0] fitted,
  output wire [11:0] diff,
  output wire cmp_true
);
  // ----------------------------------------
  // resolution fit
  // ----------------------------------------
  always @* begin
    case (res_mode)
      `MODE_8: fitted = {4'h0, raw[7:0]};
      `MODE_10: fitted = {2'h0, raw[9:0]};
      default: fitted = raw;
    endcase
  end

  // ----------------------------------------
  // difference by two's complement addition, compare by magnitude
  // ----------------------------------------
  assign diff = fitted + (~compare_value + 12'h001);
  assign cmp_true = compare_greater_select ? (fitted >= compare_value) :
                    (fitted < compare_value);
endmodule

// >>> sar_conversion_sequencer.v
// sar_conversion_sequencer: start, sequencing, abort and result handling
// assumes an AHB-Lite master, a core returning core_result while converting
`timescale 1ns/1ps
`include "sar_defs.vh"
module sar_conversion_sequencer #(
  parameter FIFO_MAX = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire hw_trigger_in,
  input wire stop_mode_req,
  input wire alt_clock_tick,
  input wire async_clock_tick,
  input wire [11:0] core_result,
  output reg [4:0] core_channel,
  output reg core_sample,
  output reg core_convert,
  output reg async_clock_enable,
  output reg irq_request
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_WAKE = 4'b0010;
  localparam [3:0] S_SAMPLE = 4'b0100;
  localparam [3:0] S_APPROX = 4'b1000;

  reg [3:0] state;
  reg [7:0] cnt;
  reg [4:0] channel_select;
  reg complete_irq_enable, continuous_enable, conversion_complete_flag;
  reg hw_trigger_select, compare_enable, compare_greater_select;
  reg low_power_config, long_sample_select;
  reg [1:0] clock_divide, res_mode, input_clock_select;
  reg compare_all_select;
  reg [2:0] fifo_depth;
  reg [11:0] compare_value, result_value;
  reg hi_read_pending, running_cont, trig_prev, any_true, all_true;
  reg [4:0] chan_fifo [0:FIFO_MAX-1];
  reg [11:0] res_fifo [0:FIFO_MAX-1];
  reg [3:0] fill_count;
  reg [2:0] conv_index, rd_index;
  reg wr_pending, rd_pending;
  reg [7:0] addr_q;
  reg [31:0] rd_word;
  integer i;

  wire tick;
  wire [11:0] fitted, diff;
  wire cmp_true;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [7:0] sample_len;
    input long;
    input first;
    begin
      sample_len = long ? 8'd`SAMPLE_LONG_TICKS : 8'd`SAMPLE_SHORT_TICKS;
      if (first)
        sample_len = sample_len + 8'd`FIRST_EXTRA_TICKS;
    end
  endfunction

  function [7:0] approx_len;
    input [1:0] mode;
    begin
      approx_len = (mode == `MODE_8) ? 8'd`APPROX_8_TICKS : 8'd`APPROX_HI_TICKS;
    end
  endfunction

  wire fifo_on = fifo_depth != 3'h0;
  wire [3:0] depth4 = {1'b0, fifo_depth};
  wire hi_res = res_mode != `MODE_8;
  wire blocked = hi_read_pending && hi_res;
  wire take = hsel && hready && htrans[1];
  wire sc1_wr = wr_pending && addr_q == `OFS_SC1;
  wire sc4_wr = wr_pending && addr_q == `OFS_SC4;
  wire cfg_wr = wr_pending && (addr_q == `OFS_SC2 || addr_q == `OFS_SC3 ||
                addr_q == `OFS_SC4 || addr_q == `OFS_CVH || addr_q == `OFS_CVL);
  wire [4:0] wr_chan = hwdata[`SC1_CHAN];
  wire stop_abort = stop_mode_req && input_clock_select != `CLK_ASYNC && state != S_IDLE;
  // edges are only looked at while idle and not already running continuously
  wire trig_edge = hw_trigger_select && hw_trigger_in && !trig_prev &&
                   state == S_IDLE && !running_cont;
  wire done = state == S_APPROX && tick && cnt == 8'h01;
  wire [2:0] fill_idx = (fill_count >= depth4) ? 3'h0 : fill_count[2:0];
  wire [3:0] fill_next = {1'b0, fill_idx} + 4'h1;
  wire [11:0] res_out = fifo_on ? res_fifo[rd_index] : result_value;
  wire any_new = (conv_index == 3'h0 ? 1'b0 : any_true) | cmp_true;
  wire all_new = (conv_index == 3'h0 ? 1'b1 : all_true) & cmp_true;
  wire [2:0] last_idx = fifo_depth - 3'h1;

  converter_clock_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(state != S_IDLE),
    .input_clock_select(input_clock_select),
    .clock_divide(clock_divide),
    .alt_clock_tick(alt_clock_tick),
    .async_clock_tick(async_clock_tick),
    .tick(tick)
  );

  result_compare u_cmp (
    .raw(core_result),
    .res_mode(res_mode),
    .compare_value(compare_value),
    .compare_greater_select(compare_greater_select),
    .fitted(fitted),
    .diff(diff),
    .cmp_true(cmp_true)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    rd_word = 32'h0000_0000;
    if (addr_q == `OFS_SC1) begin
      rd_word[`SC1_FLAG] = conversion_complete_flag;
      rd_word[`SC1_IRQEN] = complete_irq_enable;
      rd_word[`SC1_CONT] = continuous_enable;
      rd_word[`SC1_CHAN] = fifo_on ? chan_fifo[conv_index] : channel_select;
    end else if (addr_q == `OFS_SC2) begin
      rd_word[`SC2_BUSY] = state != S_IDLE;
      rd_word[`SC2_HWTRIG] = hw_trigger_select;
      rd_word[`SC2_CMPEN] = compare_enable;
      rd_word[`SC2_CMPGT] = compare_greater_select;
    end else if (addr_q == `OFS_SC3) begin
      rd_word[`SC3_LOWPWR] = low_power_config;
      rd_word[`SC3_DIV] = clock_divide;
      rd_word[`SC3_LONG] = long_sample_select;
      rd_word[`SC3_MODE] = res_mode;
      rd_word[`SC3_CLK] = input_clock_select;
    end else if (addr_q == `OFS_SC4) begin
      rd_word[`SC4_CMPALL] = compare_all_select;
      rd_word[`SC4_DEPTH] = fifo_depth;
    end else if (addr_q == `OFS_RH) begin
      rd_word[`HI_NIBBLE] = res_out[11:8];
    end else if (addr_q == `OFS_RL) begin
      rd_word[7:0] = res_out[7:0];
    end else if (addr_q == `OFS_CVH) begin
      rd_word[`HI_NIBBLE] = compare_value[11:8];
    end else if (addr_q == `OFS_CVL) begin
      rd_word[7:0] = compare_value[7:0];
    end
  end

  // ----------------------------------------
  // sequencing tasks
  // ----------------------------------------
  task go_idle;
    begin
      state <= S_IDLE;
      cnt <= 8'h00;
      core_sample <= 1'b0;
      core_convert <= 1'b0;
      async_clock_enable <= 1'b0;
      running_cont <= 1'b0;
    end
  endtask

  task start_conv;
    input [4:0] ch;
    begin
      state <= S_WAKE;
      core_channel <= ch;
      core_sample <= 1'b0;
      core_convert <= 1'b0;
      running_cont <= continuous_enable;
      // async generator only runs while converting on it
      async_clock_enable <= input_clock_select == `CLK_ASYNC;
      if (input_clock_select == `CLK_ASYNC)
        cnt <= 8'd`START_BUS_CYCLES + 8'd`ASYNC_STARTUP_CYCLES;
      else
        cnt <= 8'd`START_BUS_CYCLES;
    end
  endtask

  task next_conv;
    input [4:0] ch;
    begin
      state <= S_SAMPLE;
      core_channel <= ch;
      cnt <= sample_len(long_sample_select, 1'b0);
      core_sample <= 1'b1;
      core_convert <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // main process
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      core_channel <= `CHAN_OFF;
      core_sample <= 1'b0;
      core_convert <= 1'b0;
      async_clock_enable <= 1'b0;
      irq_request <= 1'b0;
      complete_irq_enable <= 1'b0;
      continuous_enable <= 1'b0;
      channel_select <= `CHAN_OFF;
      conversion_complete_flag <= 1'b0;
      hw_trigger_select <= 1'b0;
      compare_enable <= 1'b0;
      compare_greater_select <= 1'b0;
      low_power_config <= 1'b0;
      clock_divide <= 2'h0;
      long_sample_select <= 1'b0;
      res_mode <= `MODE_8;
      input_clock_select <= `CLK_BUS;
      compare_all_select <= 1'b0;
      fifo_depth <= 3'h0;
      compare_value <= 12'h000;
      result_value <= 12'h000;
      for (i = 0; i < FIFO_MAX; i = i + 1) begin
        chan_fifo[i] <= `CHAN_OFF;
        res_fifo[i] <= 12'h000;
      end
      hi_read_pending <= 1'b0;
      running_cont <= 1'b0;
      trig_prev <= 1'b0;
      any_true <= 1'b0;
      all_true <= 1'b0;
      fill_count <= 4'h0;
      conv_index <= 3'h0;
      rd_index <= 3'h0;
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      trig_prev <= hw_trigger_in;
      irq_request <= conversion_complete_flag && complete_irq_enable;
      wr_pending <= take && hwrite;
      rd_pending <= take && !hwrite;
      if (take)
        addr_q <= haddr[7:0];
      // reads take one wait state so a preceding write is always visible
      if (take && !hwrite)
        hreadyout <= 1'b0;
      else if (rd_pending)
        hreadyout <= 1'b1;
      if (rd_pending) begin
        hrdata <= rd_word;
        if (addr_q == `OFS_RH && hi_res)
          hi_read_pending <= 1'b1;
        if (addr_q == `OFS_RL) begin
          hi_read_pending <= 1'b0;
          conversion_complete_flag <= 1'b0;
          if (fifo_on)
            rd_index <= rd_index + 3'h1;
        end
      end
      if (wr_pending) begin
        if (addr_q == `OFS_SC1) begin
          channel_select <= wr_chan;
          complete_irq_enable <= hwdata[`SC1_IRQEN];
          continuous_enable <= hwdata[`SC1_CONT];
          conversion_complete_flag <= 1'b0;
        end else if (addr_q == `OFS_SC2) begin
          hw_trigger_select <= hwdata[`SC2_HWTRIG];
          compare_enable <= hwdata[`SC2_CMPEN];
          compare_greater_select <= hwdata[`SC2_CMPGT];
        end else if (addr_q == `OFS_SC3) begin
          low_power_config <= hwdata[`SC3_LOWPWR];
          clock_divide <= hwdata[`SC3_DIV];
          long_sample_select <= hwdata[`SC3_LONG];
          res_mode <= hwdata[`SC3_MODE];
          input_clock_select <= hwdata[`SC3_CLK];
        end else if (addr_q == `OFS_SC4) begin
          compare_all_select <= hwdata[`SC4_CMPALL];
          fifo_depth <= hwdata[`SC4_DEPTH];
        end else if (addr_q == `OFS_CVH) begin
          compare_value[11:8] <= hwdata[`HI_NIBBLE];
        end else if (addr_q == `OFS_CVL) begin
          compare_value[7:0] <= hwdata[7:0];
        end
      end
      // aborts take priority over any completion in the same cycle
      if (stop_abort || cfg_wr) begin
        go_idle;
        conv_index <= 3'h0;
        if (sc4_wr)
          fill_count <= 4'h0;
      end else if (sc1_wr) begin
        go_idle;
        conv_index <= 3'h0;
        rd_index <= 3'h0;
        if (!fifo_on) begin
          if (wr_chan != `CHAN_OFF && !hw_trigger_select)
            start_conv(wr_chan);
        end else if (wr_chan == `CHAN_OFF) begin
          fill_count <= 4'h0;
        end else begin
          chan_fifo[fill_idx] <= wr_chan;
          fill_count <= fill_next;
          if (fill_next == depth4 && !hw_trigger_select)
            start_conv(fill_idx == 3'h0 ? wr_chan : chan_fifo[0]);
        end
      end else if (trig_edge) begin
        if (!fifo_on && channel_select != `CHAN_OFF)
          start_conv(channel_select);
        else if (fifo_on && fill_count == depth4)
          start_conv(chan_fifo[conv_index]);
      end else begin
        case (state)
          S_WAKE: begin
            if (cnt == 8'h01) begin
              state <= S_SAMPLE;
              cnt <= sample_len(long_sample_select, 1'b1);
              core_sample <= 1'b1;
            end else begin
              cnt <= cnt - 8'h01;
            end
          end
          S_SAMPLE: begin
            if (tick && cnt == 8'h01) begin
              state <= S_APPROX;
              cnt <= approx_len(res_mode);
              core_sample <= 1'b0;
              core_convert <= 1'b1;
            end else if (tick) begin
              cnt <= cnt - 8'h01;
            end
          end
          S_APPROX: begin
            if (done && !fifo_on) begin
              if (compare_enable && !cmp_true) begin
                if (continuous_enable)
                  next_conv(core_channel);
                else
                  go_idle;
              end else if (blocked) begin
                next_conv(core_channel);
              end else begin
                result_value <= compare_enable ? diff : fitted;
                conversion_complete_flag <= 1'b1;
                if (continuous_enable)
                  next_conv(core_channel);
                else
                  go_idle;
              end
            end else if (done && blocked) begin
              next_conv(core_channel);
            end else if (done) begin
              res_fifo[conv_index] <= compare_enable ? diff : fitted;
              any_true <= any_new;
              all_true <= all_new;
              rd_index <= 3'h0;
              if (conv_index == last_idx) begin
                conv_index <= 3'h0;
                conversion_complete_flag <= !compare_enable ||
                  (compare_all_select ? all_new : any_new);
                if (continuous_enable) begin
                  next_conv(chan_fifo[0]);
                end else begin
                  go_idle;
                  if (!hw_trigger_select)
                    fill_count <= 4'h0;
                end
              end else begin
                conv_index <= conv_index + 3'h1;
                // hardware trigger mode waits for the next edge per entry
                if (hw_trigger_select)
                  go_idle;
                else
                  next_conv(chan_fifo[conv_index + 3'h1]);
              end
            end else if (tick) begin
              cnt <= cnt - 8'h01;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// >>> sar_seq_asserts.sv
// port checker for sar_conversion_sequencer
// assumes hready is tied to hreadyout by the bench
`timescale 1ns/1ps
module sar_seq_asserts (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [4:0] core_channel,
  input wire core_sample,
  input wire core_convert
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ------------------------------
  // bus and conversion phases
  // ------------------------------
  property p_okay;
    hresp == 1'h0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_rd_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
  property p_rd_hold;
    hreadyout && $past(hreadyout) |-> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_excl;
    !(core_sample && core_convert);
  endproperty
  a_excl: assert property (p_excl) else $error("sample and convert overlap");
  property p_conv_start;
    $rose(core_convert) |-> $past(core_sample);
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("convert without sample");
  // judged at the end of sampling, so an abort mid-sample is not a fault
  property p_sample_min;
    $rose(core_convert) |-> $past(core_sample, 4);
  endproperty
  a_sample_min: assert property (p_sample_min) else $error("sample too short");
  property p_conv_bound;
    core_convert |-> ##[1:300] !core_convert;
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("convert too long");
  // channel must not move under a running approximation
  property p_chan_stable;
    core_convert |-> $stable(core_channel);
  endproperty
  a_chan_stable: assert property (p_chan_stable) else $error("channel moved");
endmodule
bind sar_conversion_sequencer sar_seq_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .core_channel(core_channel),
  .core_sample(core_sample), .core_convert(core_convert));

// >>> sar_far_side.sv
// far side model: hardware trigger source and converter core
// assumes the bench commands each trigger pulse
`timescale 1ns/1ps
module sar_far_side (
  input wire hclk,
  input wire trig_req,
  input wire [4:0] core_channel,
  input wire core_convert,
  output reg hw_trigger_in,
  output wire alt_clock_tick,
  output wire async_clock_tick,
  output wire [11:0] core_result
);
  reg [1:0] cnt = 2'h0;
  initial hw_trigger_in = 1'h0;
  always @(posedge hclk) begin
    cnt <= cnt + 2'h1;
    hw_trigger_in <= trig_req;
  end
  assign alt_clock_tick = (cnt == 2'h0);
  assign async_clock_tick = cnt[0];
  // junk outside approximation, so a late capture shows
  assign core_result = core_convert ? {core_channel[3:0], 8'h5C} : {~core_channel[3:0], 8'hA3};
endmodule

// >>> sar_conversion_sequencer_tb.sv
// self-checking bench for sar_conversion_sequencer
// assumes sar_far_side stands for trigger source and core
`timescale 1ns/1ps
module sar_conversion_sequencer_tb;
  reg hclk = 1'h0;
  reg hresetn = 1'h0;
  reg hsel = 1'h0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'h0;
  reg [31:0] hwdata = 32'h0;
  reg stop_mode_req = 1'h0;
  reg trig_req = 1'h0;
  reg [31:0] q;
  wire [31:0] hrdata;
  wire hreadyout, hresp, hw_trigger_in, alt_clock_tick, async_clock_tick;
  wire [11:0] core_result;
  wire [4:0] core_channel;
  wire core_sample, core_convert, async_clock_enable, irq_request;
  integer num_errors = 0;
  integer n_tests = 0;
  integer i;
  always #50 hclk = ~hclk;
  sar_conversion_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hw_trigger_in(hw_trigger_in), .stop_mode_req(stop_mode_req),
    .alt_clock_tick(alt_clock_tick), .async_clock_tick(async_clock_tick),
    .core_result(core_result), .core_channel(core_channel), .core_sample(core_sample),
    .core_convert(core_convert), .async_clock_enable(async_clock_enable),
    .irq_request(irq_request));
  sar_far_side far (.hclk(hclk), .trig_req(trig_req), .core_channel(core_channel),
    .core_convert(core_convert), .hw_trigger_in(hw_trigger_in),
    .alt_clock_tick(alt_clock_tick), .async_clock_tick(async_clock_tick),
    .core_result(core_result));
  // ------------------------------
  // helpers
  // ------------------------------
  task ck(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // entered just after a rising edge, leaves at one
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      q = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d); bus(1'h1, a, d); endtask
  task rr(input [7:0] a); bus(1'h0, a, 32'h0); endtask
  task idle(input integer n); repeat (n) @(posedge hclk); endtask
  task wait_done;
    begin
      q = 32'h0;
      for (i = 0; i < 100 && q[7] !== 1'h1; i = i + 1) rr(8'h00);
    end
  endtask
  task wait_conv;
    begin
      for (i = 0; i < 100 && core_convert !== 1'h1; i = i + 1) @(posedge hclk);
      ck({31'h0, core_convert}, 32'h1);
    end
  endtask
  task pulse;
    begin
      trig_req <= 1'h1;
      idle(2);
      trig_req <= 1'h0;
      idle(1);
    end
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task t_single;
    begin
      rr(8'h20);
      ck(q, 32'h0);
      wr(8'h08, 32'h04);
      wr(8'h00, 32'h43);
      wait_done;
      ck(q, 32'hC3);
      ck({31'h0, irq_request}, 32'h1);
      rr(8'h10);
      ck(q, 32'h3);
      rr(8'h14);
      ck(q, 32'h5C);
      rr(8'h00);
      ck(q, 32'h43);
    end
  endtask
  task t_block;
    begin
      wr(8'h00, 32'h05);
      rr(8'h10);
      idle(120);
      rr(8'h00);
      ck(q, 32'h05);
      rr(8'h10);
      ck(q, 32'h3);
      rr(8'h14);
      ck(q, 32'h5C);
      wait_done;
      rr(8'h10);
      ck(q, 32'h5);
      rr(8'h14);
    end
  endtask
  task t_hw;
    begin
      wr(8'h04, 32'h40);
      wr(8'h00, 32'h06);
      pulse;
      wait_conv;
      pulse;
      wait_done;
      ck(q, 32'h86);
      rr(8'h10);
      ck(q, 32'h6);
      rr(8'h14);
      idle(60);
      ck({31'h0, core_sample | core_convert}, 32'h0);
    end
  endtask
  task t_abort;
    begin
      wr(8'h00, 32'h07);
      pulse;
      wait_conv;
      wr(8'h08, 32'h04);
      idle(2);
      ck({31'h0, core_convert}, 32'h0);
      idle(60);
      rr(8'h00);
      ck(q, 32'h07);
      rr(8'h10);
      ck(q, 32'h6);
      rr(8'h14);
    end
  endtask
  task t_cmp;
    begin
      wr(8'h04, 32'h30);
      wr(8'h18, 32'h0F);
      wr(8'h1C, 32'hFF);
      wr(8'h00, 32'h08);
      idle(100);
      rr(8'h00);
      ck(q, 32'h08);
      rr(8'h10);
      ck(q, 32'h6);
      rr(8'h14);
      wr(8'h18, 32'h08);
      wr(8'h1C, 32'h00);
      wr(8'h00, 32'h08);
      wait_done;
      rr(8'h10);
      ck(q, 32'h0);
      rr(8'h14);
      ck(q, 32'h5C);
    end
  endtask
  task t_cont;
    begin
      wr(8'h04, 32'h00);
      wr(8'h00, 32'h29);
      wait_done;
      rr(8'h10);
      ck(q, 32'h9);
      rr(8'h14);
      wait_done;
      ck(q, 32'hA9);
      stop_mode_req <= 1'h1;
      idle(80);
      stop_mode_req <= 1'h0;
      idle(80);
      ck({31'h0, core_sample | core_convert}, 32'h0);
    end
  endtask
  task t_async;
    begin
      wr(8'h08, 32'h03);
      wr(8'h00, 32'h0A);
      idle(2);
      ck({31'h0, async_clock_enable}, 32'h1);
      wait_done;
      ck(q, 32'h8A);
      ck({31'h0, async_clock_enable}, 32'h0);
      rr(8'h10);
      ck(q, 32'h0);
      rr(8'h14);
      ck(q, 32'h5C);
    end
  endtask
  task t_fifo;
    begin
      wr(8'h08, 32'h04);
      wr(8'h0C, 32'h02);
      wr(8'h00, 32'h01);
      idle(40);
      ck({31'h0, core_sample | core_convert}, 32'h0);
      wr(8'h00, 32'h02);
      wait_done;
      ck(q, 32'h81);
      rr(8'h10);
      ck(q, 32'h1);
      rr(8'h14);
      rr(8'h10);
      ck(q, 32'h2);
      rr(8'h14);
      wr(8'h0C, 32'h00);
    end
  endtask
  task t_reset;
    begin
      wr(8'h00, 32'h0B);
      wait_conv;
      hresetn <= 1'h0;
      idle(2);
      hresetn <= 1'h1;
      idle(1);
      ck({31'h0, core_sample | core_convert}, 32'h0);
      rr(8'h10);
      ck(q, 32'h0);
      rr(8'h14);
      ck(q, 32'h0);
      rr(8'h00);
      ck(q, 32'h1F);
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    idle(12);
    hresetn <= 1'h1;
    idle(1);
    t_single;
    t_block;
    t_hw;
    t_abort;
    t_cmp;
    t_cont;
    t_async;
    t_fifo;
    t_reset;
    end_sim;
  end
endmodule
